// ==== bench/mio_board.sv ====
// Board devices on the bidirectional pins, with pull-ups
`timescale 1ns/100ps
`default_nettype none
module mio_board (
	// From the port set
	input wire mio_pkg::port_vec_t ioPinOut,
	input wire mio_pkg::port_vec_t ioPinOe,
	// Board drivers
	input wire mio_pkg::port_vec_t boardVal,
	input wire mio_pkg::port_vec_t boardOe,
	// Resolved levels
	output var mio_pkg::port_vec_t ioPinIn
);
	import mio_pkg::*;
	// Undriven lines float high; contention is not modelled, port wins
	always_comb
	begin
		ioPinIn = (ioPinOut & ioPinOe) | (boardVal & boardOe & ~ioPinOe)
			| ~(ioPinOe | boardOe);
	end
endmodule // mio_board
`default_nettype wire

// ==== bench/mio_port_props.sv ====
// Port-level assertions for the multiplexed port set
`timescale 1ns/100ps
`default_nettype none
module mio_port_props (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Pins
	input wire mio_pkg::port_vec_t ioPinIn,
	input wire mio_pkg::port_vec_t ioPinOut,
	input wire mio_pkg::port_vec_t ioPinOe,
	input wire logic [15:0] anaPinIn,
	input wire logic [15:0] analog_input_channel,
	input wire logic [7:0] fastExtInt,
	// Functions
	input wire logic chipSelectEn,
	input wire logic [4:0] chipSelect_n,
	input wire logic arbitrationEn,
	input wire logic holdAck_n,
	input wire logic busRequest_n,
	input wire logic segmentEn,
	input wire logic [7:0] segmentAddr,
	input wire logic canEn,
	input wire logic canTx,
	input wire logic serialMaster,
	input wire logic extInstrRead,
	input wire logic extDataRead,
	input wire logic readStrobe_n_ff
);
	import mio_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Level the board sees; released open-drain pins look like pull-up highs
	port_vec_t lv;
	assign lv = ioPinOut | ~ioPinOe;
	// Serial master held over two edges
	sequence serialRun;
		serialMaster ##1 serialMaster;
	endsequence

	chk_read_strobe: assert property (
		1'b1 |=> readStrobe_n_ff == !$past(extInstrRead || extDataRead))
		else $error("read strobe wrong");
	chk_absent_bit: assert property (
		!ioPinOe[SLOT_P3][14] && ioPinOe[SLOT_P4][15:8] == 8'h00
		&& ioPinOe[SLOT_P6][15:8] == 8'h00
		&& ioPinOe[SLOT_P7][15:8] == 8'h00
		&& ioPinOe[SLOT_P8][15:8] == 8'h00)
		else $error("absent bit driven");
	chk_chip_selects: assert property (
		chipSelectEn |=> lv[SLOT_P6][4:0] == $past(chipSelect_n))
		else $error("chip selects wrong");
	chk_hold_pins: assert property (
		arbitrationEn |=> !ioPinOe[SLOT_P6][5]
		&& lv[SLOT_P6][7:6] == $past({busRequest_n, holdAck_n}))
		else $error("arbitration pins wrong");
	chk_can_pins: assert property (
		canEn |=> !ioPinOe[SLOT_P4][5] && lv[SLOT_P4][6] == $past(canTx))
		else $error("can pins wrong");
	chk_segment_addr: assert property (
		segmentEn && !canEn |=> lv[SLOT_P4][7:0] == $past(segmentAddr))
		else $error("segment address wrong");
	chk_serial_clock: assert property (
		serialRun |=> lv[SLOT_P3][13] != $past(lv[SLOT_P3][13]))
		else $error("serial clock stuck");
	chk_input_port: assert property (
		$past(rst_b) |-> analog_input_channel == $past(anaPinIn))
		else $error("input port sample wrong");
	chk_fast_ints: assert property (
		$past(rst_b) |-> fastExtInt == $past(ioPinIn[SLOT_P2][15:8]))
		else $error("fast interrupt sample wrong");
endmodule // mio_port_props

bind multiplexed_io_port_set mio_port_props i_props (
	.ref_clk, .rst_b, .ioPinIn, .ioPinOut, .ioPinOe, .anaPinIn,
	.analog_input_channel, .fastExtInt, .chipSelectEn, .chipSelect_n,
	.arbitrationEn, .holdAck_n, .busRequest_n, .segmentEn, .segmentAddr,
	.canEn, .canTx, .serialMaster, .extInstrRead, .extDataRead,
	.readStrobe_n_ff
);
`default_nettype wire

// ==== bench/multiplexed_io_port_set_test.sv ====
// Self-checking testbench for the multiplexed port set
`timescale 1ns/100ps
`default_nettype none
module multiplexed_io_port_set_test;
	import mio_pkg::*;
	// Implemented bits and threshold capability per slot
	localparam logic [15:0] portWidth [6] = '{16'hffff, 16'hbfff,
		16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
	localparam logic [5:0] thrCap = 6'h33;
	logic ref_clk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic [4:0] regAddr = 5'h00, chipSelect_n = 5'h00;
	logic [15:0] regWrData = 16'h0000, anaPinIn = 16'h0000;
	logic [15:0] regRdData_ff, analog_input_channel;
	port_vec_t ioPinIn, ioPinOut, ioPinOe;
	port_vec_t boardVal = '0, boardOe = '0;
	logic [5:0] thresholdSpecial_ff;
	logic [7:0] segmentAddr = 8'h00, fastExtInt;
	logic chipSelectEn = 1'b0, arbitrationEn = 1'b0, holdAck_n = 1'b0;
	logic busRequest_n = 1'b0, segmentEn = 1'b0, extInstrRead = 1'b0;
	logic extDataRead = 1'b0, highByteEn = 1'b0, writeHighMode = 1'b0;
	logic high_byte_enable_n = 1'b0, high_byte_write_strobe_n = 1'b0;
	logic canEn = 1'b0, canTx = 1'b0, serialMaster = 1'b0;
	logic [3:0] pwmEn = 4'h0, pwmOut = 4'h0;
	logic [11:0] cc2CompareEn = 12'h000, cc2CompareVal = 12'h000;
	logic [11:0] cc2CaptureIn;
	logic timer6_updown_control_in, timer6_count_in, holdRequest_n;
	logic readStrobe_n_ff, canRx, capcmp2_timer_count_in;
	int nErrors = 0, samplesChecked = 0, cycles = 0;

	multiplexed_io_port_set i_dut (
		.ref_clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd,
		.regRdData_ff, .ioPinIn, .ioPinOut, .ioPinOe, .thresholdSpecial_ff,
		.anaPinIn, .analog_input_channel, .timer6_updown_control_in,
		.timer6_count_in, .chipSelectEn, .chipSelect_n, .arbitrationEn,
		.holdAck_n, .busRequest_n, .holdRequest_n, .segmentEn, .segmentAddr,
		.extInstrRead, .extDataRead, .readStrobe_n_ff, .highByteEn,
		.writeHighMode, .high_byte_enable_n, .high_byte_write_strobe_n,
		.canEn, .canTx, .canRx, .serialMaster, .pwmEn, .pwmOut,
		.cc2CompareEn, .cc2CompareVal, .cc2CaptureIn,
		.capcmp2_timer_count_in, .fastExtInt
	);
	mio_board i_board (.ioPinOut, .ioPinOe, .boardVal, .boardOe, .ioPinIn);

	// Clock
	always #5 ref_clk = ~ref_clk;

	task automatic final_report();
		if (nErrors == 0 && samplesChecked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samplesChecked++;
		if (got !== exp)
		begin
			nErrors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 check(regRdData_ff, exp);
	endtask

	// Room for the control, driver and input sampling stages
	task automatic settle();
		repeat (4) @(posedge ref_clk);
		#1;
	endtask

	// Guard against a hang; the run needs about 150 cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			nErrors++;
			final_report();
		end
	end

	initial
	begin
		logic v;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		#1 check(ioPinOe[SLOT_P2] | ioPinOe[SLOT_P3], 16'h0000);
		rdchk({SLOT_P2, REG_DIR}, 16'h0000);
		// Width, driver enable and threshold choice of every bidirectional port
		for (int s = 0; s < NUM_PORTS; s++)
		begin
			wr({s[2:0], REG_DIR}, 16'hffff);
			wr({s[2:0], REG_CTRL}, 16'h0002);
			rdchk({s[2:0], REG_DIR}, portWidth[s]);
			settle();
			check(ioPinOe[s], portWidth[s]);
			check(16'(thresholdSpecial_ff[s]), 16'(thrCap[s]));
			wr({s[2:0], REG_DIR}, 16'h0000);
		end
		// Input-only port ignores writes; unmapped place reads zero
		wr({SLOT_P5, REG_DATA}, 16'hffff);
		rdchk({SLOT_P5, REG_DATA}, 16'h0000);
		rdchk({3'h7, REG_DATA}, 16'h0000);
		// Per-bit direction, then the same pins as open drain
		wr({SLOT_P2, REG_DATA}, 16'ha5c3);
		wr({SLOT_P2, REG_DIR}, 16'h00ff);
		settle();
		check(ioPinIn[SLOT_P2], 16'hffc3);
		check(ioPinOe[SLOT_P2], 16'h00ff);
		wr({SLOT_P2, REG_CTRL}, 16'h0001);
		settle();
		check(ioPinOe[SLOT_P2], 16'h003c);
		rdchk({SLOT_P2, REG_PIN}, 16'hffc3);
		// Input-only port and its timer inputs
		@(posedge ref_clk);
		anaPinIn <= 16'h1455;
		settle();
		check(analog_input_channel, 16'h1455);
		check(16'({timer6_count_in, timer6_updown_control_in}), 16'h0003);
		rdchk({SLOT_P5, REG_PIN}, 16'h1455);
		// Read strobe for every kind of external read
		for (int i = 0; i < 4; i++)
		begin
			@(posedge ref_clk);
			{extInstrRead, extDataRead} <= i[1:0];
			@(posedge ref_clk);
			#1 check(16'(readStrobe_n_ff), 16'(i == 0));
		end
		// Bus control and segment address claim their pins
		@(posedge ref_clk);
		chipSelectEn <= 1'b1;
		chipSelect_n <= 5'h15;
		arbitrationEn <= 1'b1;
		busRequest_n <= 1'b1;
		segmentEn <= 1'b1;
		segmentAddr <= 8'h96;
		boardOe[SLOT_P6][5] <= 1'b1;
		settle();
		check(ioPinIn[SLOT_P6], 16'hff95);
		check(16'(holdRequest_n), 16'h0000);
		check(ioPinIn[SLOT_P4], 16'hff96);
		// CAN takes two segment lines over
		@(posedge ref_clk);
		canEn <= 1'b1;
		canTx <= 1'b1;
		boardOe[SLOT_P4][5] <= 1'b1;
		boardVal[SLOT_P4][5] <= 1'b1;
		settle();
		check(ioPinIn[SLOT_P4], 16'hfff6);
		check(16'(canRx), 16'h0001);
		// High-byte pin in both write modes, serial clock as master
		@(posedge ref_clk);
		highByteEn <= 1'b1;
		high_byte_write_strobe_n <= 1'b1;
		serialMaster <= 1'b1;
		settle();
		check(16'(ioPinIn[SLOT_P3][12]), 16'h0000);
		@(posedge ref_clk);
		writeHighMode <= 1'b1;
		settle();
		check(16'(ioPinIn[SLOT_P3][12]), 16'h0001);
		for (int i = 0; i < 4; i++)
		begin
			v = ioPinIn[SLOT_P3][13];
			@(posedge ref_clk);
			#1 check(16'(ioPinIn[SLOT_P3][13]), 16'(!v));
		end
		// Compare and pulse outputs replace the latches
		@(posedge ref_clk);
		cc2CompareEn <= 12'hfff;
		cc2CompareVal <= 12'ha5c;
		pwmEn <= 4'hf;
		pwmOut <= 4'h9;
		settle();
		check(ioPinIn[SLOT_P8], 16'hff5c);
		check(ioPinIn[SLOT_P7], 16'hffa9);
		// Compare off: the same pins capture what the board drives
		@(posedge ref_clk);
		cc2CompareEn <= 12'h000;
		boardOe[SLOT_P8] <= 16'h00ff;
		boardVal[SLOT_P8] <= 16'h003e;
		boardOe[SLOT_P7] <= 16'h00f0;
		boardVal[SLOT_P7] <= 16'h0070;
		boardOe[SLOT_P2] <= 16'hff00;
		boardVal[SLOT_P2] <= 16'h8100;
		settle();
		check(16'(cc2CaptureIn), 16'h073e);
		check(16'({capcmp2_timer_count_in, fastExtInt}), 16'h0181);
		final_report();
	end
endmodule // multiplexed_io_port_set_test
`default_nettype wire

// ==== common/mio_pkg.sv ====
// Shared constants, layouts and carrier types for the multiplexed port set
package mio_pkg;

	// Port slot numbering: six bidirectional ports, then the input-only port
	localparam int NUM_PORTS = 6;
	localparam int PORT_W = 16;
	localparam logic [2:0] SLOT_P2 = 3'h0;
	localparam logic [2:0] SLOT_P3 = 3'h1;
	localparam logic [2:0] SLOT_P4 = 3'h2;
	localparam logic [2:0] SLOT_P6 = 3'h3;
	localparam logic [2:0] SLOT_P7 = 3'h4;
	localparam logic [2:0] SLOT_P8 = 3'h5;
	localparam logic [2:0] SLOT_P5 = 3'h6;

	// Register address: {slot, register select}
	localparam int ADDR_W = 5;
	localparam int SEL_W = 2;
	localparam logic [1:0] REG_DATA = 2'h0;
	localparam logic [1:0] REG_DIR = 2'h1;
	localparam logic [1:0] REG_CTRL = 2'h2;
	localparam logic [1:0] REG_PIN = 2'h3;

	// Control register fields
	localparam int CTRL_OD_BIT = 0;
	localparam int CTRL_THR_BIT = 1;

	// Implemented bits per slot; bit 14 of the 15-bit port is absent
	localparam logic [NUM_PORTS-1:0][PORT_W-1:0] PORT_MASK = {
		16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'hbfff, 16'hffff};
	localparam logic [PORT_W-1:0] P5_MASK = 16'hffff;
	// Slots that offer a selectable input threshold
	localparam logic [NUM_PORTS-1:0] THRESH_CAP = 6'h33;

	// Reset values
	localparam logic [PORT_W-1:0] DATA_RST = 16'h0000;
	localparam logic [PORT_W-1:0] DIR_RST = 16'h0000;
	localparam logic [PORT_W-1:0] RD_RST = 16'h0000;

	// Pin positions of the alternate functions
	localparam int CS_LSB = 0;
	localparam int CS_NUM = 5;
	localparam int HOLD_REQ_BIT = 5;
	localparam int HOLD_ACK_BIT = 6;
	localparam int BUS_REQ_BIT = 7;
	localparam int CAN_RX_BIT = 5;
	localparam int CAN_TX_BIT = 6;
	localparam int SEG_W = 8;
	localparam int FAST_INT_LSB = 8;
	localparam int FAST_INT_NUM = 8;
	localparam int CC2_TIMER_BIT = 15;
	localparam int HIGH_BYTE_BIT = 12;
	localparam int SERIAL_CLK_BIT = 13;
	localparam int PWM_NUM = 4;
	localparam int CC2_LOW_NUM = 8;
	localparam int CC2_HIGH_LSB = 4;
	localparam int CC2_HIGH_NUM = 4;
	localparam int CC2_NUM = 12;
	localparam int T6_UPDOWN_BIT = 10;
	localparam int T6_COUNT_BIT = 12;

	// Software controls of one port
	typedef struct packed {
		logic [PORT_W-1:0] latch;
		logic [PORT_W-1:0] dir;
		logic openDrain;
	} port_ctrl_t;

	// On-chip function claims on one port
	typedef struct packed {
		logic [PORT_W-1:0] outEn;
		logic [PORT_W-1:0] outVal;
		logic [PORT_W-1:0] inForce;
	} port_alt_t;

	typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_vec_t;

endpackage

// ==== hdl/io_pin_cell.sv ====
// One port's pin drivers and input sampling
`timescale 1ns/100ps
`default_nettype none
module io_pin_cell #(
	parameter logic [15:0] MASK = 16'hffff
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Controls
	input wire mio_pkg::port_ctrl_t ctrl,
	input wire mio_pkg::port_alt_t alt,
	// Pins
	input wire logic [15:0] pinIn,
	output logic [15:0] pinOut_ff,
	output logic [15:0] pinOe_ff,
	output logic [15:0] pinSync_ff
);
	import mio_pkg::*;

	logic [PORT_W-1:0] value;
	logic [PORT_W-1:0] wantDrive;
	logic [PORT_W-1:0] nxt_pinOe;
	logic [PORT_W-1:0] nxt_pinOut;

	// Function value replaces the latch where a function owns the pin
	assign value = (alt.outEn & alt.outVal) | (~alt.outEn & ctrl.latch);
	// Output direction or a function claim drives; an input claim turns the driver off
	assign wantDrive = (ctrl.dir | alt.outEn) & ~alt.inForce & MASK;
	// Open drain only pulls low; a high level releases the pin
	assign nxt_pinOe = ctrl.openDrain ? (wantDrive & ~value) : wantDrive;
	assign nxt_pinOut = ctrl.openDrain ? '0 : (value & wantDrive);

	// Registered drivers, so the pins never glitch on mux changes
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pinOut_ff <= DATA_RST;
			pinOe_ff <= DIR_RST;
		end
		else
		begin
			pinOut_ff <= nxt_pinOut;
			pinOe_ff <= nxt_pinOe;
		end
	end

	// Input sampling; missing bits read zero
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			pinSync_ff <= DATA_RST;
		else
			pinSync_ff <= pinIn & MASK;
	end

endmodule // io_pin_cell
`default_nettype wire

// ==== hdl/multiplexed_io_port_set.sv ====
// Port set top: registers, function multiplexing and dedicated strobes
// What this block does
// - Every bidirectional pin has its own direction bit, input or output.
// - A pin set to input and not claimed by a function has its driver switched off.
// - Each bidirectional port selects push-pull or open-drain drivers.
// - Some ports offer a software choice of TTL or special threshold.
// - A 16-bit input-only port feeds analog channels and timer 6 inputs.
// - One port has 15 bits, with bit 14 absent entirely.
// - The segment port drives address lines 16 to 23 in bus mode.
// - With CAN on, segment bit 5 is CAN receive and bit 6 CAN transmit.
// - The read strobe is active for every external instruction or data read.
// - As serial master, port 3 bit 13 outputs a clock equal to the CPU clock.
// - Port 6 bits 0-4 are chip selects, 5 hold request, 6 ack, 7 bus request.
// - Port 2 bits 8-15 are fast interrupts, bit 15 also the timer 7 input.
// - Port 3 bit 12 is high-byte enable or high-byte write by configuration.
// - Second capture unit channels 16-23 on port 8 and 28-31 on port 7.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module multiplexed_io_port_set (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [mio_pkg::ADDR_W-1:0] regAddr,
	input wire logic [mio_pkg::PORT_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [mio_pkg::PORT_W-1:0] regRdData_ff,
	// Bidirectional port pins
	input wire mio_pkg::port_vec_t ioPinIn,
	output var mio_pkg::port_vec_t ioPinOut,
	output var mio_pkg::port_vec_t ioPinOe,
	output logic [mio_pkg::NUM_PORTS-1:0] thresholdSpecial_ff,
	// Input-only port
	input wire logic [mio_pkg::PORT_W-1:0] anaPinIn,
	output logic [mio_pkg::PORT_W-1:0] analog_input_channel,
	output logic timer6_updown_control_in,
	output logic timer6_count_in,
	// External bus controls
	input wire logic chipSelectEn,
	input wire logic [mio_pkg::CS_NUM-1:0] chipSelect_n,
	input wire logic arbitrationEn,
	input wire logic holdAck_n,
	input wire logic busRequest_n,
	output logic holdRequest_n,
	input wire logic segmentEn,
	input wire logic [mio_pkg::SEG_W-1:0] segmentAddr,
	input wire logic extInstrRead,
	input wire logic extDataRead,
	output logic readStrobe_n_ff,
	input wire logic highByteEn,
	input wire logic writeHighMode,
	input wire logic high_byte_enable_n,
	input wire logic high_byte_write_strobe_n,
	// CAN
	input wire logic canEn,
	input wire logic canTx,
	output logic canRx,
	// Serial master clock
	input wire logic serialMaster,
	// Pulse width outputs
	input wire logic [mio_pkg::PWM_NUM-1:0] pwmEn,
	input wire logic [mio_pkg::PWM_NUM-1:0] pwmOut,
	// Second capture/compare unit
	input wire logic [mio_pkg::CC2_NUM-1:0] cc2CompareEn,
	input wire logic [mio_pkg::CC2_NUM-1:0] cc2CompareVal,
	output logic [mio_pkg::CC2_NUM-1:0] cc2CaptureIn,
	output logic capcmp2_timer_count_in,
	// Fast external interrupts
	output logic [mio_pkg::FAST_INT_NUM-1:0] fastExtInt
);
	import mio_pkg::*;

	logic [PORT_W-1:0] latch_ff [NUM_PORTS];
	logic [PORT_W-1:0] dir_ff [NUM_PORTS];
	logic [NUM_PORTS-1:0] openDrain_ff;
	logic [PORT_W-1:0] anaSync_ff;
	logic cpuClk_ff;
	port_ctrl_t ctrl [NUM_PORTS];
	port_alt_t alt [NUM_PORTS];
	port_vec_t pinSync;
	logic [2:0] slot;
	logic [1:0] regSel;
	logic [PORT_W-1:0] nxt_regRdData;
	logic [NUM_PORTS-1:0] wrSlot;
	logic latchWr;
	logic dirWr;
	logic ctrlWr;

	// Address split: port slot above, register select below
	assign slot = regAddr[ADDR_W-1:SEL_W];
	assign regSel = regAddr[SEL_W-1:0];

	// Write decode; slots 6 and 7 select nothing, so those writes drop
	always_comb
	begin
		wrSlot = '0;
		if (slot == SLOT_P2)
			wrSlot[SLOT_P2] = 1'b1;
		else if (slot == SLOT_P3)
			wrSlot[SLOT_P3] = 1'b1;
		else if (slot == SLOT_P4)
			wrSlot[SLOT_P4] = 1'b1;
		else if (slot == SLOT_P6)
			wrSlot[SLOT_P6] = 1'b1;
		else if (slot == SLOT_P7)
			wrSlot[SLOT_P7] = 1'b1;
		else if (slot == SLOT_P8)
			wrSlot[SLOT_P8] = 1'b1;
	end

	// One strobe per register kind; the pin register takes no writes
	assign latchWr = regWr && regSel == REG_DATA;
	assign dirWr = regWr && regSel == REG_DIR;
	assign ctrlWr = regWr && regSel == REG_CTRL;

	// Port latches written by software; absent bits never store
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
				latch_ff[p] <= DATA_RST;
		end
		else if (latchWr)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
				if (wrSlot[p])
					latch_ff[p] <= regWrData & PORT_MASK[p];
		end
	end

	// Direction bits, one per pin; reset leaves every pin an input
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
				dir_ff[p] <= DIR_RST;
		end
		else if (dirWr)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
				if (wrSlot[p])
					dir_ff[p] <= regWrData & PORT_MASK[p];
		end
	end

	// Driver style per port
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			openDrain_ff <= '0;
		else if (ctrlWr)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
				if (wrSlot[p])
					openDrain_ff[p] <= regWrData[CTRL_OD_BIT];
		end
	end

	// Threshold choice; ports without the option keep standard level
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			thresholdSpecial_ff <= '0;
		else if (ctrlWr)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
				if (wrSlot[p])
					thresholdSpecial_ff[p] <=
						regWrData[CTRL_THR_BIT] & THRESH_CAP[p];
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		nxt_regRdData = RD_RST;
		if (slot == SLOT_P5)
		begin
			// Input-only port offers just its pin register
			if (regSel == REG_PIN)
				nxt_regRdData = anaSync_ff;
		end
		else if (slot < 3'(NUM_PORTS))
		begin
			if (regSel == REG_DATA)
				nxt_regRdData = latch_ff[slot];
			else if (regSel == REG_DIR)
				nxt_regRdData = dir_ff[slot];
			else if (regSel == REG_CTRL)
			begin
				nxt_regRdData[CTRL_OD_BIT] = openDrain_ff[slot];
				nxt_regRdData[CTRL_THR_BIT] = thresholdSpecial_ff[slot];
			end
			else if (regSel == REG_PIN)
				nxt_regRdData = pinSync[slot];
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			regRdData_ff <= RD_RST;
		else if (regRd)
			regRdData_ff <= nxt_regRdData;
		else
			regRdData_ff <= RD_RST;
	end

	// Input-only port has no drivers, only sampling
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			anaSync_ff <= DATA_RST;
		else
			anaSync_ff <= anaPinIn & P5_MASK;
	end

	// Read strobe low for any external read, instruction or data
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			readStrobe_n_ff <= 1'b1;
		else
			readStrobe_n_ff <= ~(extInstrRead | extDataRead);
	end

	// CPU clock is ref_clk halved; the serial clock follows it one ref_clk cycle later
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			cpuClk_ff <= 1'b0;
		else
			cpuClk_ff <= ~cpuClk_ff;
	end

	// Port 2: fast interrupts are inputs only, no driver claim
	always_comb
	begin
		alt[SLOT_P2] = '0;
	end

	// Port 3: high-byte strobe and serial master clock
	always_comb
	begin
		alt[SLOT_P3] = '0;
		alt[SLOT_P3].outEn[HIGH_BYTE_BIT] = highByteEn;
		// Write configuration picks which strobe owns the pin
		alt[SLOT_P3].outVal[HIGH_BYTE_BIT] = writeHighMode ?
			high_byte_write_strobe_n : high_byte_enable_n;
		alt[SLOT_P3].outEn[SERIAL_CLK_BIT] = serialMaster;
		alt[SLOT_P3].outVal[SERIAL_CLK_BIT] = cpuClk_ff;
	end

	// Port 4: segment address, with CAN taking bits 5 and 6
	always_comb
	begin
		alt[SLOT_P4] = '0;
		alt[SLOT_P4].outEn[SEG_W-1:0] = {SEG_W{segmentEn}};
		alt[SLOT_P4].outVal[SEG_W-1:0] = segmentAddr;
		if (canEn)
		begin
			// CAN wins over the address lines it displaces
			alt[SLOT_P4].outEn[CAN_RX_BIT] = 1'b0;
			alt[SLOT_P4].inForce[CAN_RX_BIT] = 1'b1;
			alt[SLOT_P4].outEn[CAN_TX_BIT] = 1'b1;
			alt[SLOT_P4].outVal[CAN_TX_BIT] = canTx;
		end
	end

	// Port 6: chip selects and bus arbitration
	always_comb
	begin
		alt[SLOT_P6] = '0;
		alt[SLOT_P6].outEn[CS_LSB +: CS_NUM] = {CS_NUM{chipSelectEn}};
		alt[SLOT_P6].outVal[CS_LSB +: CS_NUM] = chipSelect_n;
		alt[SLOT_P6].inForce[HOLD_REQ_BIT] = arbitrationEn;
		alt[SLOT_P6].outEn[HOLD_ACK_BIT] = arbitrationEn;
		alt[SLOT_P6].outVal[HOLD_ACK_BIT] = holdAck_n;
		alt[SLOT_P6].outEn[BUS_REQ_BIT] = arbitrationEn;
		alt[SLOT_P6].outVal[BUS_REQ_BIT] = busRequest_n;
	end

	// Port 7: pulse width low nibble, compare channels in high nibble
	always_comb
	begin
		alt[SLOT_P7] = '0;
		alt[SLOT_P7].outEn[PWM_NUM-1:0] = pwmEn;
		alt[SLOT_P7].outVal[PWM_NUM-1:0] = pwmOut;
		alt[SLOT_P7].outEn[CC2_HIGH_LSB +: CC2_HIGH_NUM] =
			cc2CompareEn[CC2_LOW_NUM +: CC2_HIGH_NUM];
		alt[SLOT_P7].outVal[CC2_HIGH_LSB +: CC2_HIGH_NUM] =
			cc2CompareVal[CC2_LOW_NUM +: CC2_HIGH_NUM];
	end

	// Port 8: compare channels on every bit
	always_comb
	begin
		alt[SLOT_P8] = '0;
		alt[SLOT_P8].outEn[CC2_LOW_NUM-1:0] = cc2CompareEn[CC2_LOW_NUM-1:0];
		alt[SLOT_P8].outVal[CC2_LOW_NUM-1:0] = cc2CompareVal[CC2_LOW_NUM-1:0];
	end

	// One pin cell per port, each with its own implemented-bit mask
	generate
		for (genvar g = 0; g < NUM_PORTS; g++)
		begin : g_port
			always_comb
			begin
				ctrl[g].latch = latch_ff[g];
				ctrl[g].dir = dir_ff[g];
				ctrl[g].openDrain = openDrain_ff[g];
			end

			io_pin_cell #(
				.MASK(PORT_MASK[g])
			) u_cell (
				.ref_clk(ref_clk),
				.rst_b(rst_b),
				.ctrl(ctrl[g]),
				.alt(alt[g]),
				.pinIn(ioPinIn[g]),
				.pinOut_ff(ioPinOut[g]),
				.pinOe_ff(ioPinOe[g]),
				.pinSync_ff(pinSync[g])
			);
		end
	endgenerate

	// Function inputs come straight from the sampled pin registers
	assign analog_input_channel = anaSync_ff;
	assign timer6_updown_control_in = anaSync_ff[T6_UPDOWN_BIT];
	assign timer6_count_in = anaSync_ff[T6_COUNT_BIT];
	assign fastExtInt = pinSync[SLOT_P2][FAST_INT_LSB +: FAST_INT_NUM];
	assign capcmp2_timer_count_in = pinSync[SLOT_P2][CC2_TIMER_BIT];
	assign holdRequest_n = pinSync[SLOT_P6][HOLD_REQ_BIT];
	assign canRx = pinSync[SLOT_P4][CAN_RX_BIT];
	// Capture always sees the pin, whoever drives it
	assign cc2CaptureIn = {pinSync[SLOT_P7][CC2_HIGH_LSB +: CC2_HIGH_NUM],
		pinSync[SLOT_P8][CC2_LOW_NUM-1:0]};

endmodule // multiplexed_io_port_set
`default_nettype wire
